// File: sim/pin_load.sv
// Load model on the compare port pins, feeding levels back.
// Assumes the bench may override a pin as an outside driver.
`timescale 1ns/1ns
module pin_load
	import t2cmp_pkg::*;
(
	// Pins from the device
	input wire logic [NUM_CH-1:0] pin_in,
	// Outside driver
	input wire logic [NUM_CH-1:0] ext_en_in,
	input wire logic [NUM_CH-1:0] ext_lvl_in,
	// Levels seen at the pins
	output logic [NUM_CH-1:0] level_out
);
	// Outside driver wins over the device pin
	assign level_out = (ext_en_in & ext_lvl_in) | (~ext_en_in & pin_in);
endmodule

// File: sim/t2cmp_monitor.sv
// Checker for the timer-2 compare unit.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
module t2cmp_monitor
	import t2cmp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [DATA_W-1:0] rd_data_out,
	// Pins
	input wire logic [NUM_CH-1:0] cap_pin_in,
	input wire logic [NUM_CH-1:0] cmp_pin_out,
	input wire logic [P5_W-1:0] port5_out,
	input wire logic [NUM_CH-1:0] irq_flag_out
);
	logic timer_two_cmp_mode_bit;
	logic [1:0] sel1;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Shadow of mode bit and channel one select
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_two_cmp_mode_bit <= 1'b0;
			sel1 <= SEL_OFF;
		end else if (wr_in && addr_in == OFS_T2CTL) begin
			timer_two_cmp_mode_bit <= wr_data_in[TIMER_TWO_CMP_MODE_BIT_BIT];
		end else if (wr_in && addr_in == OFS_CCSEL) begin
			sel1 <= wr_data_in[3:2];
		end
	end
	reset_level_a: assert property ($rose(rst_n_in) |->
		cmp_pin_out == RST_P1 && port5_out == RST_P5 && irq_flag_out == '0)
		else $error("bad level after reset");
	idle_read_a: assert property (!$past(rd_in) |-> rd_data_out == '0)
		else $error("read data outside read");
	unmapped_read_a: assert property (rd_in && addr_in == 8'h0a |=> rd_data_out == '0)
		else $error("unmapped read not zero");
	mode_read_a: assert property (rd_in && addr_in == OFS_T2CTL |=>
		rd_data_out[TIMER_TWO_CMP_MODE_BIT_BIT] == $past(timer_two_cmp_mode_bit)) else $error("mode bit lost");
	sel_read_a: assert property (rd_in && addr_in == OFS_CCSEL |=>
		rd_data_out[3:2] == $past(sel1)) else $error("select field lost");
	multi_mode_a: assert property (wr_in && addr_in == OFS_R4EN && wr_data_in[COEN_BIT] ##2
		rd_in && addr_in == OFS_R4EN |=> rd_data_out[REG_FOUR_MODE_BIT_BIT]) else $error("mode not forced");
	mode0_lock_a: assert property (wr_in && addr_in == OFS_P1LAT && !timer_two_cmp_mode_bit && sel1 == SEL_CMP
		|=> $stable(cmp_pin_out[1]) [*3]) else $error("port write moved pin");
	shadow_hold_a: assert property (wr_in && addr_in == OFS_P1LAT && timer_two_cmp_mode_bit && sel1 == SEL_CMP
		|=> $stable(cmp_pin_out[1]) [*3]) else $error("shadow write moved pin");
	cover property ($rose(cmp_pin_out[1]));
	cover property ($fell(port5_out[0]));
	cover property ($rose(irq_flag_out[4]));
endmodule
bind timer2_compare_concurrent t2cmp_monitor mon_u (.ref_clk_in, .rst_n_in, .addr_in,
	.wr_data_in, .wr_in, .rd_in, .rd_data_out, .cap_pin_in, .cmp_pin_out, .port5_out,
	.irq_flag_out);

// File: sim/timer2_compare_concurrent_test.sv
// Bench for the timer-2 compare unit with its pin loads.
// Assumes a 50 MHz clock and the register map of the package.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module timer2_compare_concurrent_test
	import t2cmp_pkg::*;
;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr_in = '0;
	logic [7:0] wr_data_in = '0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [4:0] ext_en = '0;
	logic [4:0] ext_lvl = '0;
	logic [7:0] rd_data_out;
	logic [4:0] cap_pin_in;
	logic [4:0] cmp_pin_out;
	logic [4:0] irq_flag_out;
	logic [7:0] port5_out;
	logic [7:0] d;
	logic [7:0] t0;
	logic [7:0] t1;
	int n_mismatch = 0;
	int checks = 0;
	int n;
	timer2_compare_concurrent dut_u (.ref_clk_in, .rst_n_in, .addr_in, .wr_data_in, .wr_in,
		.rd_in, .rd_data_out, .cap_pin_in, .cmp_pin_out, .port5_out, .irq_flag_out);
	pin_load load_u (.pin_in(cmp_pin_out), .ext_en_in(ext_en), .ext_lvl_in(ext_lvl),
		.level_out(cap_pin_in));
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr_in <= a;
		wr_data_in <= v;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		@(negedge ref_clk_in);
		v = rd_data_out;
		@(posedge ref_clk_in);
	endtask
	task automatic wait_pin(input logic lvl);
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (cmp_pin_out[1] !== lvl && n < 4000);
		@(posedge ref_clk_in);
	endtask
	task automatic t_reset();
		@(negedge ref_clk_in);
		`CHK(cmp_pin_out, RST_P1)
		`CHK(port5_out, RST_P5)
		`CHK(irq_flag_out, 5'h00)
		@(posedge ref_clk_in);
		rd(8'h0a, d);
		rd(OFS_R4EN, d);
		`CHK(d, RST_REG8)
		rd(OFS_TMR_LO, t0);
		repeat (22) @(posedge ref_clk_in);
		rd(OFS_TMR_LO, t1);
		`CHK(t1, t0 + 8'h02)
	endtask
	task automatic t_capture();
		for (int i = 0; i < NUM_CH; i++) begin
			if (i < 4) begin
				wr(OFS_CCSEL, 8'(int'(SEL_CAP_WR) << (2 * i)));
			end else begin
				wr(OFS_R4EN, 8'(int'(SEL_CAP_WR) << R4SEL_LO));
			end
			rd(OFS_TMR_LO, t0);
			wr(OFS_CMP_BASE + 8'(2 * i), 8'h5a);
			rd(OFS_TMR_LO, t1);
			rd(OFS_CMP_BASE + 8'(2 * i), d);
			`CHK(d >= t0 && d <= t1, 1'b1)
		end
		wr(OFS_R4EN, 8'h00);
		wr(OFS_CCSEL, 8'h04);
		ext_en <= 5'h02;
		repeat (5) @(posedge ref_clk_in);
		rd(OFS_TMR_LO, t0);
		ext_lvl <= 5'h02;
		repeat (6) @(posedge ref_clk_in);
		rd(OFS_TMR_LO, t1);
		rd(OFS_CMP_BASE + 8'h02, d);
		`CHK(d >= t0 && d <= t1, 1'b1)
		wr(OFS_R4EN, 8'(int'(SEL_CAP_PIN) << R4SEL_LO));
		rd(OFS_TMR_LO, t0);
		ext_en <= 5'h12;
		repeat (6) @(posedge ref_clk_in);
		rd(OFS_TMR_LO, t1);
		rd(OFS_CMP_BASE + 8'h08, d);
		`CHK(d >= t0 && d <= t1, 1'b1)
		ext_en <= 5'h00;
	endtask
	task automatic t_pwm(input logic [15:0] v, input int w);
		wr(OFS_T2CTL, 8'h00);
		wr(OFS_CCSEL, 8'h08);
		w16(OFS_CMP_BASE + 8'h02, v);
		w16(OFS_TMR_LO, 16'hffe0);
		wait_pin(1'b0);
		wr(OFS_P1LAT, 8'h1f);
		wr(OFS_FLAGS, 8'h1f);
		wait_pin(1'b1);
		wait_pin(1'b0);
		`CHK(n, w)
		`CHK(irq_flag_out[1], 1'b1)
	endtask
	task automatic t_mode1();
		wr(OFS_T2CTL, 8'h01);
		w16(OFS_CMP_BASE + 8'h02, 16'hfff0);
		wr(OFS_P1LAT, 8'h1f);
		w16(OFS_TMR_LO, 16'hffe0);
		wait_pin(1'b1);
		repeat (20) @(posedge ref_clk_in);
		wr(OFS_P1LAT, 8'h1d);
		wait_pin(1'b0);
		`CHK(n >= 3000 && n < 4000, 1'b1)
	endtask
	task automatic t_conc();
		wr(OFS_T2CTL, 8'h04);
		wr(OFS_P1LAT, 8'h1f);
		w16(OFS_CMP_BASE + 8'h08, 16'hfff0);
		wr(OFS_R4EN, 8'h3c);
		rd(OFS_R4EN, d);
		`CHK(d, 8'h3d)
		w16(OFS_TMR_LO, 16'hff80);
		wr(OFS_FLAGS, 8'h1f);
		wr(OFS_P5LAT, 8'h00);
		wr(OFS_P1LAT, 8'h0f);
		@(negedge ref_clk_in);
		`CHK(port5_out, 8'h0f)
		`CHK(cmp_pin_out[4], 1'b1)
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (port5_out !== 8'h00 && n < 2000);
		`CHK(n < 2000, 1'b1)
		`CHK(irq_flag_out[4], 1'b0)
		repeat (20) @(negedge ref_clk_in);
		`CHK(irq_flag_out[4], 1'b1)
		`CHK(cmp_pin_out[4], 1'b0)
		@(posedge ref_clk_in);
	endtask
	task automatic end_sim();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		forever #10 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(posedge ref_clk_in);
		t_reset();
		t_capture();
		w16(OFS_RLD_LO, 16'hff00);
		t_pwm(16'hfff0, 16 * MACHINE_DIV - 1);
		t_pwm(16'hffff, MACHINE_DIV - 1);
		t_mode1();
		t_conc();
		end_sim();
	end
endmodule

// File: src/cmp_channel.sv
// One compare channel: comparator, mode 0 and mode 1 output latch.
// Assumes timer and shadow value come from flops on the same clock.
`timescale 1ns/1ns
module cmp_channel
	import t2cmp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Time base
	input wire logic [TIMER_W-1:0] timer_in,
	input wire logic overflow_in,
	// Configuration
	input wire logic [TIMER_W-1:0] value_in,
	input wire logic cmp_en_in,
	input wire logic mode1_in,
	input wire logic shadow_in,
	// Results
	output logic pin_out,
	output logic active_out,
	output logic rise_out,
	output logic fall_out
);
	logic active_q;
	logic pin;
	logic next_pin;
	logic active;

	// Compare signal while count equals register
	assign active = cmp_en_in && (timer_in == value_in);
	assign active_out = active;
	assign rise_out = active && !active_q;
	assign fall_out = !active && active_q;
	assign pin_out = pin;

	always_comb begin
		next_pin = pin;
		if (!cmp_en_in) begin
			next_pin = shadow_in;
		end else if (!mode1_in) begin
			// Port writes ignored; match sets, overflow clears
			if (rise_out) begin
				next_pin = 1'b1;
			end else if (overflow_in) begin
				next_pin = 1'b0;
			end
		end else if (active) begin
			// Shadow passes through while compare is active
			next_pin = shadow_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin <= 1'b1;
			active_q <= 1'b0;
		end else begin
			pin <= next_pin;
			active_q <= active;
		end
	end
endmodule

// File: src/t2cmp_pkg.sv
// Constants for the timer-2 compare unit with concurrent compare.
// Assumes an 8-bit register port with one-cycle read latency.
package t2cmp_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int TIMER_W = 16;
	localparam int NUM_CH = 5;
	localparam int P5_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_T2CTL = 8'h00;
	localparam logic [7:0] OFS_CCSEL = 8'h01;
	localparam logic [7:0] OFS_R4EN = 8'h02;
	localparam logic [7:0] OFS_P1LAT = 8'h03;
	localparam logic [7:0] OFS_P5LAT = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h05;
	localparam logic [7:0] OFS_TMR_LO = 8'h06;
	localparam logic [7:0] OFS_TMR_HI = 8'h07;
	localparam logic [7:0] OFS_RLD_LO = 8'h08;
	localparam logic [7:0] OFS_RLD_HI = 8'h09;
	localparam logic [7:0] OFS_CMP_BASE = 8'h10;

	// Field positions in timer_two_control
	localparam int TIMER_TWO_CMP_MODE_BIT_BIT = 0;
	localparam int RLD_NEG_BIT = 1;
	localparam int R4_NEG_BIT = 2;

	// Field positions in reg_four_enable
	localparam int REG_FOUR_MODE_BIT_BIT = 0;
	localparam int R4SEL_LO = 1;
	localparam int COEN_BIT = 3;
	localparam int CNT_LO = 4;

	// Select field codes
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_CAP_PIN = 2'h1;
	localparam logic [1:0] SEL_CMP = 2'h2;
	localparam logic [1:0] SEL_CAP_WR = 2'h3;

	// Reset values
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [4:0] RST_P1 = 5'h1f;
	localparam logic [7:0] RST_P5 = 8'hff;

	// Machine cycle: oscillator divided by twelve
	localparam int MACHINE_DIV = 12;
	localparam logic [3:0] PRESC_LAST = 4'(MACHINE_DIV - 1);
	localparam logic [15:0] TIMER_MAX = 16'hffff;
endpackage

// File: src/timer2_compare_concurrent.sv
// Timer-2 compare unit: reload/compare register, compare regs one to
// four, capture selection and concurrent compare onto port 5.
// Assumes capture pins are asynchronous and the register port is
// driven from logic on ref_clk_in.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns

// Behaviour
// - Five registers compare against timer two when their select is compare
// - One control bit picks mode for four
// - Reload register select: off, edge, compare, write
// - Regs one-three select: off, rising, compare, write
// - Low byte write latches count when selected
// - Reload and reg four interrupt edge selectable
// - Regs one-three interrupt on rising edge only, compare or pin
// - Mode 0 PWM never reaches full duty
// - Spike split between reload and maximum match
// - Timer two counts once per twelve clocks
// - Reg four has own enable and mode
// - Reg four match moves nine-bit pattern out
// - Outputs are reg four pin plus port five
// - Multi-output enable also sets reg four mode
// - Three-bit field sets extra port-five pins
// - Reg four pin serves every compare mode
// - Mode 0: match sets, overflow clears, writes ignored
// - Mode 1: shadow moves out on match
// - Count field enables bits zero through value
module timer2_compare_concurrent
	import t2cmp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [DATA_W-1:0] rd_data_out,
	// Capture and interrupt pins
	input wire logic [NUM_CH-1:0] cap_pin_in,
	// Compare outputs
	output logic [NUM_CH-1:0] cmp_pin_out,
	output logic [P5_W-1:0] port5_out,
	output logic [NUM_CH-1:0] irq_flag_out
);
	logic [7:0] timer_two_control;
	logic [7:0] compare_capture_select;
	logic [7:0] reg_four_enable;
	logic [4:0] p1_shadow;
	logic [P5_W-1:0] p5_shadow;
	logic [P5_W-1:0] p5_out;
	logic [NUM_CH-1:0] flags;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] reload;
	logic [TIMER_W-1:0] cmp_val [NUM_CH];
	logic [3:0] presc;
	logic [NUM_CH-1:0] sync1;
	logic [NUM_CH-1:0] sync2;
	logic [NUM_CH-1:0] pin_prev;
	logic [DATA_W-1:0] rd_data;

	logic [7:0] next_timer_two_control;
	logic [7:0] next_compare_capture_select;
	logic [7:0] next_reg_four_enable;
	logic [4:0] next_p1_shadow;
	logic [P5_W-1:0] next_p5_shadow;
	logic [P5_W-1:0] next_p5_out;
	logic [NUM_CH-1:0] next_flags;
	logic [TIMER_W-1:0] next_timer;
	logic [TIMER_W-1:0] next_reload;
	logic [TIMER_W-1:0] next_cmp_val [NUM_CH];
	logic [3:0] next_presc;
	logic [DATA_W-1:0] next_rd_data;

	logic tick;
	logic overflow;
	logic [1:0] sel [NUM_CH];
	logic [NUM_CH-1:0] cmp_en;
	logic [NUM_CH-1:0] mode1;
	logic [NUM_CH-1:0] neg_edge;
	logic [NUM_CH-1:0] active;
	logic [NUM_CH-1:0] c_rise;
	logic [NUM_CH-1:0] c_fall;
	logic [NUM_CH-1:0] pin_rise;
	logic [NUM_CH-1:0] pin_fall;
	logic [P5_W-1:0] p5_mask;
	logic wr_t2ctl;

	// Address of compare register low or high byte
	function automatic logic [7:0] cmp_addr(input int ch, input logic hi);
		cmp_addr = OFS_CMP_BASE + 8'(2 * ch) + {7'h00, hi};
	endfunction

	// Port five bits driven by concurrent compare
	function automatic logic [P5_W-1:0] extra_mask(input logic [2:0] cnt);
		extra_mask = 8'hff >> (3'h7 - cnt);
	endfunction

	// Machine-cycle divider and timer two
	assign tick = (presc == PRESC_LAST);
	assign overflow = tick && (timer == TIMER_MAX);
	assign pin_rise = sync2 & ~pin_prev;
	assign pin_fall = ~sync2 & pin_prev;
	assign wr_t2ctl = wr_in && (addr_in == OFS_T2CTL);

	// Per-channel configuration
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (i < 4) begin
				sel[i] = compare_capture_select[2*i +: 2];
				mode1[i] = timer_two_control[TIMER_TWO_CMP_MODE_BIT_BIT];
			end else begin
				sel[i] = reg_four_enable[R4SEL_LO +: 2];
				mode1[i] = reg_four_enable[REG_FOUR_MODE_BIT_BIT] | reg_four_enable[COEN_BIT];
			end
			cmp_en[i] = (sel[i] == SEL_CMP);
			neg_edge[i] = 1'b0;
		end
		neg_edge[0] = timer_two_control[RLD_NEG_BIT];
		neg_edge[4] = timer_two_control[R4_NEG_BIT];
	end

	// Compare channels; reg four pin is used in every mode
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		cmp_channel u_ch (
			.ref_clk_in(ref_clk_in),
			.rst_n_in(rst_n_in),
			.timer_in(timer),
			.overflow_in(overflow),
			.value_in(cmp_val[g]),
			.cmp_en_in(cmp_en[g]),
			.mode1_in(mode1[g]),
			.shadow_in(p1_shadow[g]),
			.pin_out(cmp_pin_out[g]),
			.active_out(active[g]),
			.rise_out(c_rise[g]),
			.fall_out(c_fall[g])
		);
	end

	// Concurrent compare outputs on port five
	assign p5_mask = reg_four_enable[COEN_BIT]
		? extra_mask(reg_four_enable[CNT_LO +: 3]) : 8'h00;

	always_comb begin
		for (int b = 0; b < P5_W; b++) begin
			if (!p5_mask[b]) begin
				next_p5_out[b] = p5_shadow[b];
			end else if (active[4]) begin
				next_p5_out[b] = p5_shadow[b];
			end else begin
				next_p5_out[b] = p5_out[b];
			end
		end
	end

	// Register writes, timer, captures and flags
	always_comb begin
		next_timer_two_control = timer_two_control;
		next_compare_capture_select = compare_capture_select;
		next_reg_four_enable = reg_four_enable;
		next_p1_shadow = p1_shadow;
		next_p5_shadow = p5_shadow;
		next_reload = reload;
		next_presc = tick ? 4'h0 : presc + 4'h1;
		next_timer = timer;
		if (overflow) begin
			next_timer = reload;
		end else if (tick) begin
			next_timer = timer + 16'h0001;
		end
		next_flags = flags;
		for (int i = 0; i < NUM_CH; i++) begin
			next_cmp_val[i] = cmp_val[i];
		end
		if (wr_in) begin
			case (addr_in)
				OFS_T2CTL: next_timer_two_control = wr_data_in;
				OFS_CCSEL: next_compare_capture_select = wr_data_in;
				OFS_R4EN: begin
					next_reg_four_enable = wr_data_in;
					next_reg_four_enable[REG_FOUR_MODE_BIT_BIT] = wr_data_in[REG_FOUR_MODE_BIT_BIT]
						| wr_data_in[COEN_BIT];
				end
				OFS_P1LAT: next_p1_shadow = wr_data_in[4:0];
				OFS_P5LAT: next_p5_shadow = wr_data_in;
				OFS_FLAGS: next_flags = flags & ~wr_data_in[NUM_CH-1:0];
				OFS_TMR_LO: next_timer[7:0] = wr_data_in;
				OFS_TMR_HI: next_timer[15:8] = wr_data_in;
				OFS_RLD_LO: next_reload[7:0] = wr_data_in;
				OFS_RLD_HI: next_reload[15:8] = wr_data_in;
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr_in == cmp_addr(i, 1'b0)) begin
					if (sel[i] == SEL_CAP_WR) begin
						next_cmp_val[i] = timer;
					end else begin
						next_cmp_val[i][7:0] = wr_data_in;
					end
				end
				if (addr_in == cmp_addr(i, 1'b1)) begin
					next_cmp_val[i][15:8] = wr_data_in;
				end
			end
		end
		for (int i = 0; i < NUM_CH; i++) begin
			// Pin edge capture: any edge on 0 and 4, rising on 1-3
			if (sel[i] == SEL_CAP_PIN) begin
				if (pin_rise[i] || (pin_fall[i] && (i == 0 || i == 4))) begin
					next_cmp_val[i] = timer;
				end
			end
			// Set wins over a simultaneous clear
			if (cmp_en[i]) begin
				if (neg_edge[i] ? c_fall[i] : c_rise[i]) begin
					next_flags[i] = 1'b1;
				end
			end else if (neg_edge[i] ? pin_fall[i] : pin_rise[i]) begin
				next_flags[i] = 1'b1;
			end
		end
	end

	// Read data, one cycle after the strobe
	always_comb begin
		next_rd_data = 8'h00;
		if (rd_in) begin
			case (addr_in)
				OFS_T2CTL: next_rd_data = timer_two_control;
				OFS_CCSEL: next_rd_data = compare_capture_select;
				OFS_R4EN: next_rd_data = reg_four_enable;
				OFS_P1LAT: next_rd_data = {3'h0, cmp_pin_out};
				OFS_P5LAT: next_rd_data = p5_out;
				OFS_FLAGS: next_rd_data = {3'h0, flags};
				OFS_TMR_LO: next_rd_data = timer[7:0];
				OFS_TMR_HI: next_rd_data = timer[15:8];
				OFS_RLD_LO: next_rd_data = reload[7:0];
				OFS_RLD_HI: next_rd_data = reload[15:8];
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (addr_in == cmp_addr(i, 1'b0)) begin
							next_rd_data = cmp_val[i][7:0];
						end
						if (addr_in == cmp_addr(i, 1'b1)) begin
							next_rd_data = cmp_val[i][15:8];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_two_control <= RST_REG8;
			compare_capture_select <= RST_REG8;
			reg_four_enable <= RST_REG8;
			p1_shadow <= RST_P1;
			p5_shadow <= RST_P5;
			p5_out <= RST_P5;
			flags <= '0;
			timer <= RST_REG16;
			reload <= RST_REG16;
			presc <= 4'h0;
			sync1 <= '1;
			sync2 <= '1;
			pin_prev <= '1;
			rd_data <= RST_REG8;
			for (int i = 0; i < NUM_CH; i++) begin
				cmp_val[i] <= RST_REG16;
			end
		end else begin
			timer_two_control <= next_timer_two_control;
			compare_capture_select <= next_compare_capture_select;
			reg_four_enable <= next_reg_four_enable;
			p1_shadow <= next_p1_shadow;
			p5_shadow <= next_p5_shadow;
			p5_out <= next_p5_out;
			flags <= next_flags;
			timer <= next_timer;
			reload <= next_reload;
			presc <= next_presc;
			sync1 <= cap_pin_in;
			sync2 <= sync1;
			pin_prev <= sync2;
			rd_data <= next_rd_data;
			for (int i = 0; i < NUM_CH; i++) begin
				cmp_val[i] <= next_cmp_val[i];
			end
		end
	end

	assign rd_data_out = rd_data;
	assign port5_out = p5_out;
	assign irq_flag_out = flags;
endmodule
